/* File: hw/exc_unit.sv */
// Exception sequencing unit: traps, trace, privilege and bus error
// ---------------------------------------------------------------
// Operation
// - Trap saves status, supervisor, trace off, vector
// - Trap pushes next pc and status, vectors
// - Software trap always raises its exception
// - Overflow and bounds traps only on condition
// - Divides trap on zero divisor
// - Illegal opcodes, fixed three patterns, raise illegal
// - Top nibble a or f use own vectors
// - Illegal pushes group 2 frame then vectors
// - Privileged instruction in user mode traps
// - Privilege violation pushes current pc and status
// - Trace bit at start raises trace after
// - No trace for aborted or unexecuted instructions
// - Instruction exception, then trace, then interrupt
// - Trace between instructions pushes next pc
// - Bus error aborts and starts fault processing
// - Fault pc lies 2 to 10 past opcode
// - Long frame holds opcode, address, flags, code
// - Read flag one; not-instruction flag one
// - Group 2 counts as instruction processing
// - Fault at vector step saves vector address
// - Fault during group 0 halts until reset
// ---------------------------------------------------------------
//
`timescale 1ns/100ps

module exc_unit
  import exc_unit_pkg::*;
#(
  parameter int VEC_ADDR_W = 32
) (
  input  wire logic                      ref_clk_in,
  input  wire logic                      nrst_in,
  input  wire exc_unit_pkg::instr_report_t report_in,
  input  wire exc_unit_pkg::bus_fault_t  fault_in,
  input  wire logic [15:0]               sr_in,
  input  wire logic                      irq_pending_in,
  input  wire logic                      vector_step_in,
  input  wire logic                      push_ready_in,
  output logic                           busy_out,
  output logic                           halted_out,
  output logic                           abort_out,
  output logic                           sr_load_out,
  output logic [15:0]                    sr_new_out,
  output logic [7:0]                     vector_out,
  output logic [VEC_ADDR_W-1:0]          vector_addr_out,
  output logic                           vector_go_out,
  output exc_unit_pkg::push_word_t       push_out,
  output logic                           irq_allow_out
);
  import exc_unit_pkg::*;
`include "exc_unit_regs.svh"

  typedef enum logic [2:0] {
    ST_RUN,
    ST_PUSH,
    ST_TRACE_WAIT,
    ST_VECTOR,
    ST_HALT
  } seq_state_t;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Status word as it is after any exception entry
  function automatic logic [15:0] enter_super(input logic [15:0] sr);
    logic [15:0] r;
    r = sr;
    r[`SR_SUPER_BIT] = 1'b1;
    r[`SR_TRACE_BIT] = 1'b0;
    return r;
  endfunction : enter_super

  function automatic logic [VEC_ADDR_W-1:0] vec_to_addr(input logic [7:0] v);
    return VEC_ADDR_W'({v, 2'b00});
  endfunction : vec_to_addr

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  seq_state_t   state_q;
  exc_group_t   group_q;
  logic [15:0]  sr_copy_q;
  logic [31:0]  saved_pc_q;
  logic [15:0]  op_copy_q;
  logic [31:0]  fault_addr_q;
  logic [4:0]   fault_info_q;
  logic [2:0]   word_idx_q;
  logic [2:0]   word_cnt_q;
  logic         trace_armed_q;
  logic         trace_due_q;
  logic [31:0]  trace_pc_q;
  logic [7:0]   vector_q;
  logic         in_vec_step_q;

  // ---------------------------------------------------------------
  // Instruction exception decode
  // ---------------------------------------------------------------
  logic        instr_exc;
  logic        instr_exc_keeps_trace;
  logic [7:0]  instr_vec;
  logic [31:0] instr_pc;
  logic        user_mode;

  assign user_mode = ~sr_in[`SR_SUPER_BIT];

  // Priority among one instruction's own exceptions; fixed patterns first
  always_comb begin
    instr_exc = 1'b0;
    instr_exc_keeps_trace = 1'b0;
    instr_vec = `VEC_ILLEGAL;
    instr_pc = report_in.next_pc;
    if (report_in.opcode[15:12] == `OP_TOP_LINE_A) begin
      instr_exc = 1'b1;
      instr_vec = `VEC_LINE_A;
      instr_pc = report_in.pc;
    end else if (report_in.opcode[15:12] == `OP_TOP_LINE_F) begin
      instr_exc = 1'b1;
      instr_vec = `VEC_LINE_F;
      instr_pc = report_in.pc;
    end else if (report_in.opcode == `OP_ILLEGAL_A || report_in.opcode == `OP_ILLEGAL_B ||
                 report_in.opcode == `OP_ILLEGAL_C || !report_in.legal) begin
      instr_exc = 1'b1;
      instr_vec = `VEC_ILLEGAL;
      instr_pc = report_in.pc;
    end else if (report_in.privileged && user_mode) begin
      instr_exc = 1'b1;
      instr_vec = `VEC_PRIVILEGE;
      instr_pc = report_in.pc;
    end else if (report_in.sw_trap) begin
      instr_exc = 1'b1;
      instr_exc_keeps_trace = 1'b1;
      instr_vec = `VEC_SW_TRAP_BASE | {4'h0, report_in.opcode[3:0]};
    end else if (report_in.overflow_trap && report_in.overflow) begin
      instr_exc = 1'b1;
      instr_exc_keeps_trace = 1'b1;
      instr_vec = `VEC_OVERFLOW;
    end else if (report_in.bounds_check && report_in.out_of_range) begin
      instr_exc = 1'b1;
      instr_exc_keeps_trace = 1'b1;
      instr_vec = `VEC_BOUNDS;
    end else if (report_in.divide && report_in.divisor_zero) begin
      instr_exc = 1'b1;
      instr_exc_keeps_trace = 1'b1;
      instr_vec = `VEC_ZERO_DIVIDE;
    end
  end

  logic instr_done;
  assign instr_done = (state_q == ST_RUN) && report_in.valid && !fault_in.fault;

  // ---------------------------------------------------------------
  // Main sequencer
  // ---------------------------------------------------------------
  // A fault beats every other event, including a completing instruction
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ST_RUN;
      group_q <= GRP_NONE;
      vector_q <= 8'h00;
      saved_pc_q <= 32'h0000_0000;
      word_cnt_q <= 3'd0;
    end else begin
      case (state_q)
        ST_RUN, ST_PUSH, ST_TRACE_WAIT, ST_VECTOR: begin
          if (fault_in.fault) begin
            if (group_q == GRP_0) begin
              state_q <= ST_HALT;
            end else begin
              state_q <= ST_PUSH;
              group_q <= GRP_0;
              vector_q <= fault_in.addr_fault ? `VEC_ADDR_ERROR : `VEC_BUS_ERROR;
              word_cnt_q <= `LONG_FRAME_WORDS;
              // Vector-step fault keeps the vector address as pc
              saved_pc_q <= in_vec_step_q ? 32'(vec_to_addr(vector_q))
                                          : report_in.pc + 32'd2;
            end
          end else if (state_q == ST_RUN && instr_done && instr_exc) begin
            state_q <= ST_PUSH;
            group_q <= GRP_2;
            vector_q <= instr_vec;
            saved_pc_q <= instr_pc;
            word_cnt_q <= `SHORT_FRAME_WORDS;
          end else if ((state_q == ST_RUN && instr_done && trace_armed_q) ||
                       (state_q == ST_TRACE_WAIT)) begin
            state_q <= ST_PUSH;
            group_q <= GRP_1;
            vector_q <= `VEC_TRACE;
            saved_pc_q <= (state_q == ST_TRACE_WAIT) ? trace_pc_q : report_in.next_pc;
            word_cnt_q <= `SHORT_FRAME_WORDS;
          end else if (state_q == ST_PUSH && push_ready_in &&
                       word_idx_q == word_cnt_q - 3'd1) begin
            state_q <= ST_VECTOR;
          end else if (state_q == ST_VECTOR && !vector_step_in && in_vec_step_q) begin
            // Pending trace from a trapping instruction goes next
            state_q <= trace_due_q ? ST_TRACE_WAIT : ST_RUN;
            group_q <= trace_due_q ? GRP_1 : GRP_NONE;
          end
        end
        ST_HALT: state_q <= ST_HALT;
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // Vector step tracking for the final exception stage
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      in_vec_step_q <= 1'b0;
    end else begin
      in_vec_step_q <= (state_q == ST_VECTOR) && vector_step_in;
    end
  end

  // ---------------------------------------------------------------
  // Trace arming
  // ---------------------------------------------------------------
  // Trace bit is sampled at the start of each instruction
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trace_armed_q <= 1'b0;
      trace_due_q <= 1'b0;
      trace_pc_q <= 32'h0000_0000;
    end else if (fault_in.fault) begin
      trace_armed_q <= 1'b0;
      trace_due_q <= 1'b0;
    end else if (instr_done) begin
      // Traps that ran still trace; unexecuted opcodes do not
      trace_due_q <= trace_armed_q && instr_exc && instr_exc_keeps_trace;
      trace_pc_q <= report_in.next_pc;
      trace_armed_q <= sr_in[`SR_TRACE_BIT];
    end else if (state_q == ST_TRACE_WAIT) begin
      trace_due_q <= 1'b0;
    end else if (state_q == ST_RUN && !report_in.valid) begin
      trace_armed_q <= sr_in[`SR_TRACE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Frame capture
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sr_copy_q <= `SR_RESET;
      op_copy_q <= 16'h0000;
      fault_addr_q <= 32'h0000_0000;
      fault_info_q <= 5'h00;
    end else if (state_q != ST_HALT && state_q != ST_PUSH &&
                 (fault_in.fault || (instr_done && (instr_exc || trace_armed_q)))) begin
      sr_copy_q <= sr_in;
      op_copy_q <= report_in.opcode;
      fault_addr_q <= fault_in.address;
      // Read is one; not-instruction is one outside normal or group 2
      fault_info_q <= {fault_in.is_read,
                       (group_q == GRP_0 || group_q == GRP_1),
                       fault_in.func_code};
    end
  end

  // ---------------------------------------------------------------
  // Stack word pusher
  // ---------------------------------------------------------------
  // Order from stack top: status, pc hi, pc lo, then descriptors
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      word_idx_q <= 3'd0;
    end else if (state_q != ST_PUSH || fault_in.fault) begin
      word_idx_q <= 3'd0;
    end else if (push_ready_in) begin
      word_idx_q <= word_idx_q + 3'd1;
    end
  end

  always_comb begin
    push_out.valid = (state_q == ST_PUSH);
    push_out.last = (word_idx_q == word_cnt_q - 3'd1);
    case (word_idx_q)
      3'd0: push_out.data = sr_copy_q;
      3'd1: push_out.data = saved_pc_q[31:16];
      3'd2: push_out.data = saved_pc_q[15:0];
      3'd3: push_out.data = op_copy_q;
      3'd4: push_out.data = fault_addr_q[31:16];
      3'd5: push_out.data = fault_addr_q[15:0];
      3'd6: push_out.data = {11'h000, fault_info_q};
      default: push_out.data = 16'h0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign busy_out = (state_q != ST_RUN);
  assign halted_out = (state_q == ST_HALT);
  assign abort_out = fault_in.fault && (state_q != ST_HALT);
  assign sr_load_out = (state_q == ST_PUSH) && (word_idx_q == 3'd0);
  assign sr_new_out = enter_super(sr_copy_q);
  assign vector_out = vector_q;
  assign vector_addr_out = vec_to_addr(vector_q);
  assign vector_go_out = (state_q == ST_VECTOR);
  // Interrupts wait until trace work is done
  assign irq_allow_out = (state_q == ST_RUN) && !trace_due_q && irq_pending_in;

endmodule : exc_unit

/* File: hw/exc_unit_regs.svh */
// Constants for the exception sequencing unit
`ifndef EXC_UNIT_REGS_SVH
`define EXC_UNIT_REGS_SVH

// Status word field positions
`define SR_TRACE_BIT      15
`define SR_SUPER_BIT      13

// Vector numbers
`define VEC_BUS_ERROR     8'h02
`define VEC_ADDR_ERROR    8'h03
`define VEC_ILLEGAL       8'h04
`define VEC_ZERO_DIVIDE   8'h05
`define VEC_BOUNDS        8'h06
`define VEC_OVERFLOW      8'h07
`define VEC_PRIVILEGE     8'h08
`define VEC_TRACE         8'h09
`define VEC_LINE_A        8'h0a
`define VEC_LINE_F        8'h0b
`define VEC_SW_TRAP_BASE  8'h20

// Opcode patterns that always trap: three decode as illegal, two top nibbles take the line A and F vectors
`define OP_ILLEGAL_A      16'h4afa
`define OP_ILLEGAL_B      16'h4afb
`define OP_ILLEGAL_C      16'h4afc
`define OP_TOP_LINE_A     4'ha
`define OP_TOP_LINE_F     4'hf

// Frame word counts
`define SHORT_FRAME_WORDS 3'd3
`define LONG_FRAME_WORDS  3'd7

// Reset value of the status word: supervisor, trace off
`define SR_RESET          16'h2700

`endif

/* File: hw/exc_unit_pkg.sv */
// Types shared by the exception sequencing unit
package exc_unit_pkg;

  // Instruction-boundary report from the execution pipeline
  typedef struct packed {
    logic        valid;
    logic [15:0] opcode;
    logic [31:0] pc;
    logic [31:0] next_pc;
    logic        legal;
    logic        privileged;
    logic        sw_trap;
    logic        overflow_trap;
    logic        overflow;
    logic        bounds_check;
    logic        out_of_range;
    logic        divide;
    logic        divisor_zero;
  } instr_report_t;

  // Bus fault descriptor from the bus interface
  typedef struct packed {
    logic        fault;
    logic        addr_fault;
    logic [31:0] address;
    logic        is_read;
    logic [2:0]  func_code;
  } bus_fault_t;

  // One word for the stack pusher
  typedef struct packed {
    logic        valid;
    logic        last;
    logic [15:0] data;
  } push_word_t;

  // Exception groups
  typedef enum logic [1:0] {
    GRP_NONE,
    GRP_0,
    GRP_1,
    GRP_2
  } exc_group_t;

endpackage : exc_unit_pkg

/* File: test/exc_unit_monitor.sv */
// Port checker for the exception sequencing unit
`timescale 1ns/100ps
`include "exc_unit_regs.svh"
module exc_unit_monitor #(
  parameter int VEC_ADDR_W = 32
) (
  input wire logic                        ref_clk_in,
  input wire logic                        nrst_in,
  input wire exc_unit_pkg::instr_report_t report_in,
  input wire exc_unit_pkg::bus_fault_t    fault_in,
  input wire logic [15:0]                 sr_in,
  input wire logic                        push_ready_in,
  input wire logic                        busy_out,
  input wire logic                        halted_out,
  input wire logic                        abort_out,
  input wire logic                        sr_load_out,
  input wire logic [15:0]                 sr_new_out,
  input wire logic [7:0]                  vector_out,
  input wire logic [VEC_ADDR_W-1:0]       vector_addr_out,
  input wire logic                        vector_go_out,
  input wire exc_unit_pkg::push_word_t    push_out
);
  import exc_unit_pkg::*;
  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  // Report is only taken when idle and no fault competes
  wire take = report_in.valid && !busy_out && !halted_out && !fault_in.fault;
  vec_scale_a: assert property (vector_go_out |-> vector_addr_out == VEC_ADDR_W'({vector_out, 2'b00}))
    else $error("vector address not four times vector");
  sr_entry_a: assert property (sr_load_out |-> sr_new_out[`SR_SUPER_BIT] && !sr_new_out[`SR_TRACE_BIT])
    else $error("new status not supervisor with trace off");
  sw_trap_a: assert property (take && report_in.sw_trap |=> busy_out && push_out.valid)
    else $error("software trap not taken");
  bad_op_a: assert property (take && (!report_in.legal || report_in.privileged && !sr_in[`SR_SUPER_BIT]) |=> busy_out)
    else $error("illegal or privileged opcode not trapped");
  div_zero_a: assert property (take && report_in.divide && report_in.divisor_zero |=> busy_out)
    else $error("zero divisor not trapped");
  quiet_op_a: assert property (take && report_in[8:0] == 9'h100 && !sr_in[`SR_TRACE_BIT] &&
    report_in.opcode[15:12] != 4'ha && report_in.opcode[15:12] != 4'hf &&
    !(report_in.opcode inside {`OP_ILLEGAL_A, `OP_ILLEGAL_B, `OP_ILLEGAL_C}) |=> !busy_out)
    else $error("plain instruction raised an exception");
  fault_abort_a: assert property (fault_in.fault && !halted_out |-> abort_out)
    else $error("bus fault did not abort");
  halt_hold_a: assert property (halted_out |=> halted_out && !push_out.valid && !vector_go_out)
    else $error("halted unit resumed activity");
  push_hold_a: assert property (push_out.valid && !push_ready_in && !fault_in.fault |=> push_out.valid && $stable(push_out.data))
    else $error("stalled push word changed");
endmodule : exc_unit_monitor

bind exc_unit exc_unit_monitor #(.VEC_ADDR_W(VEC_ADDR_W)) exc_unit_monitor_i (.ref_clk_in, .nrst_in,
  .report_in, .fault_in, .sr_in, .push_ready_in, .busy_out, .halted_out, .abort_out, .sr_load_out,
  .sr_new_out, .vector_out, .vector_addr_out, .vector_go_out, .push_out);

/* File: test/bus_fault_source.sv */
// Model of the external bus logic that reports bus faults
`timescale 1ns/100ps
module bus_fault_source (
  input  wire logic                     ref_clk_in,
  input  wire logic                     req_in,
  input  wire logic [31:0]              addr_in,
  input  wire logic                     rd_in,
  input  wire logic [2:0]               fc_in,
  output exc_unit_pkg::bus_fault_t      fault_out
);
  import exc_unit_pkg::*;
  initial fault_out = '0;
  // One-cycle fault pulse; released lines show junk, not stale data
  always @(posedge ref_clk_in) begin
    if (req_in)
      fault_out <= '{1'b1, 1'b0, addr_in, rd_in, fc_in};
    else
      fault_out <= '{1'b0, 1'b0, ~fault_out.address, ~fault_out.is_read, ~fault_out.func_code};
  end
endmodule : bus_fault_source

/* File: test/exc_unit_test.sv */
// Self-checking bench for the exception sequencing unit
`timescale 1ns/100ps
`include "exc_unit_regs.svh"
module exc_unit_test;
  import exc_unit_pkg::*;
  localparam logic [31:0] pc_cur = 32'h0012_3400;
  localparam logic [31:0] pc_next = 32'h0012_3404;
  logic          ref_clk_in = 1'b0;
  logic          nrst_in = 1'b0;
  instr_report_t report_in = '0;
  bus_fault_t    fault_in;
  logic [15:0]   sr_in = 16'h2000;
  logic          irq_pending_in = 1'b0;
  logic          vector_step_in = 1'b0;
  logic          push_ready_in = 1'b0;
  logic          busy_out, halted_out, abort_out, sr_load_out, vector_go_out, irq_allow_out;
  logic [15:0]   sr_new_out;
  logic [7:0]    vector_out;
  logic [31:0]   vector_addr_out, faddr = '0;
  push_word_t    push_out;
  logic          req = 1'b0, frd = 1'b0;
  logic [2:0]    ffc = '0;
  logic [15:0]   w [8];
  int            n_errors = 0, compares = 0;
  // Rows: opcode, flags, status word, expected vector (zero for none)
  logic [48:0]   rows [16] = '{
    {16'h4e45, 9'h140, 16'h0000, `VEC_SW_TRAP_BASE | 8'h05},
    {16'h4e76, 9'h130, 16'h2000, `VEC_OVERFLOW}, {16'h4e76, 9'h120, 16'h2000, 8'h00},
    {16'h4180, 9'h10c, 16'h0000, `VEC_BOUNDS}, {16'h4180, 9'h108, 16'h0000, 8'h00},
    {16'h81c0, 9'h103, 16'h2000, `VEC_ZERO_DIVIDE}, {16'h80c0, 9'h102, 16'h2000, 8'h00},
    {`OP_ILLEGAL_A, 9'h100, 16'h2000, `VEC_ILLEGAL}, {`OP_ILLEGAL_B, 9'h100, 16'h2000, `VEC_ILLEGAL},
    {`OP_ILLEGAL_C, 9'h100, 16'h2000, `VEC_ILLEGAL}, {16'ha123, 9'h000, 16'h0000, `VEC_LINE_A},
    {16'hf456, 9'h000, 16'h0000, `VEC_LINE_F}, {16'h46c0, 9'h180, 16'h0000, `VEC_PRIVILEGE},
    {16'h46c0, 9'h180, 16'h2000, 8'h00}, {16'h4e71, 9'h100, 16'h8000, `VEC_TRACE},
    {16'h4e71, 9'h100, 16'h0000, 8'h00}};

  always #2.5 ref_clk_in = ~ref_clk_in;

  exc_unit exc_unit_i (.ref_clk_in, .nrst_in, .report_in, .fault_in, .sr_in, .irq_pending_in,
    .vector_step_in, .push_ready_in, .busy_out, .halted_out, .abort_out, .sr_load_out,
    .sr_new_out, .vector_out, .vector_addr_out, .vector_go_out, .push_out, .irq_allow_out);
  bus_fault_source bus_fault_source_i (.ref_clk_in, .req_in(req), .addr_in(faddr),
    .rd_in(frd), .fc_in(ffc), .fault_out(fault_in));

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask : check

  task automatic conclude;
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // Status word leads the report by a cycle: trace is armed at instruction start
  task automatic issue(input logic [15:0] op, input logic [8:0] fl, input logic [15:0] s);
    @(posedge ref_clk_in);
    sr_in <= s;
    @(posedge ref_clk_in);
    report_in <= {1'b1, op, pc_cur, pc_next, fl};
    @(posedge ref_clk_in);
    report_in.valid <= 1'b0;
  endtask : issue

  task automatic fault(input logic [31:0] a, input logic r, input logic [2:0] f);
    @(posedge ref_clk_in);
    req <= 1'b1;
    faddr <= a;
    frd <= r;
    ffc <= f;
    @(posedge ref_clk_in);
    req <= 1'b0;
  endtask : fault

  // Collect a frame with the stack stalling every other cycle
  task automatic frame(input int nw, input logic [7:0] ev, input logic hit);
    int k;
    int t;
    k = 0;
    for (t = 0; t < 60 && k < nw; t++) begin
      @(negedge ref_clk_in);
      if (push_out.valid === 1'b1 && push_ready_in === 1'b1) begin
        w[k] = push_out.data;
        if (k == 0)
          check("new status", {15'h0, 1'b1, (sr_in | 16'h2000) & 16'h7fff}, {sr_load_out, sr_new_out});
        if (k == nw - 1)
          check("last word", 32'h1, push_out.last);
        k++;
      end
      @(posedge ref_clk_in);
      push_ready_in <= ~push_ready_in;
    end
    check("frame words", nw, k);
    for (t = 0; t < 20 && vector_go_out !== 1'b1; t++)
      @(negedge ref_clk_in);
    check("vector", ev, vector_out);
    check("vector address", {22'h0, ev, 2'b00}, vector_addr_out);
    @(posedge ref_clk_in);
    vector_step_in <= 1'b1;
    if (hit)
      fault(32'h0000_0094, 1'b1, 3'b110);
    @(posedge ref_clk_in);
    vector_step_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask : frame

  // ----------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------
  initial begin
    logic [15:0] op, s;
    logic [8:0]  fl;
    logic [7:0]  ev;
    repeat (20) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      {op, fl, s, ev} = rows[i];
      issue(op, fl, s);
      if (ev == 8'h00) begin
        repeat (3) @(negedge ref_clk_in);
        check("idle", 32'h0, busy_out);
      end else begin
        frame(3, ev, 1'b0);
        check("status copy", s, w[0]);
        check("saved pc", (ev inside {`VEC_ILLEGAL, `VEC_LINE_A, `VEC_LINE_F, `VEC_PRIVILEGE})
          ? pc_cur : pc_next, {w[1], w[2]});
      end
    end
    // Trap with trace armed and an interrupt waiting: trap, then trace
    @(posedge ref_clk_in) irq_pending_in <= 1'b1;
    issue(16'h4e4f, 9'h140, 16'h8000);
    frame(3, `VEC_SW_TRAP_BASE | 8'h0f, 1'b0);
    @(negedge ref_clk_in);
    check("irq held", 32'h0, irq_allow_out);
    frame(3, `VEC_TRACE, 1'b0);
    check("trace pc", pc_next, {w[1], w[2]});
    @(negedge ref_clk_in);
    check("irq allowed", 32'h1, irq_allow_out);
    @(posedge ref_clk_in) irq_pending_in <= 1'b0;
    // Bus fault between instructions, long frame, no trace after it
    fault(32'h00ab_cd10, 1'b1, 3'b101);
    frame(7, `VEC_BUS_ERROR, 1'b0);
    check("fault pc", pc_cur + 32'd2, {w[1], w[2]});
    check("opcode copy", 16'h4e4f, w[3]);
    check("fault address", 32'h00ab_cd10, {w[4], w[5]});
    check("access word", {11'h0, 1'b1, 1'b0, 3'b101}, w[6]);
    repeat (4) @(negedge ref_clk_in);
    check("no trace", 32'h0, busy_out);
    // Fault while the vector is fetched saves the vector address
    issue(16'h4e43, 9'h140, 16'h2000);
    frame(3, `VEC_SW_TRAP_BASE | 8'h03, 1'b1);
    frame(7, `VEC_BUS_ERROR, 1'b0);
    check("vector pc", {22'h0, `VEC_SW_TRAP_BASE | 8'h03, 2'b00}, {w[1], w[2]});
    // Second fault inside fault processing halts until reset
    fault(32'h0000_0400, 1'b0, 3'b001);
    fault(32'h0000_0402, 1'b0, 3'b001);
    repeat (3) @(negedge ref_clk_in);
    check("halted", 32'h1, halted_out);
    issue(16'h4e41, 9'h140, 16'h2000);
    repeat (3) @(negedge ref_clk_in);
    check("halt quiet", 32'h0, push_out.valid);
    @(posedge ref_clk_in) nrst_in <= 1'b0;
    repeat (2) @(negedge ref_clk_in);
    check("reset state", 32'h0, {halted_out, busy_out, push_out.valid, vector_out});
    @(posedge ref_clk_in) nrst_in <= 1'b1;
    issue(16'h4e41, 9'h140, 16'h2000);
    frame(3, `VEC_SW_TRAP_BASE | 8'h01, 1'b0);
    conclude();
  end

  // Watchdog: the sequence needs well under 4000 cycles
  initial begin
    #20000;
    n_errors++;
    conclude();
  end
endmodule : exc_unit_test
